/* File: verilog/sac_pkg.sv */
// Shared constants and carrier types for the converter control block.
package sac_pkg;
   // Converter geometry and timing counts.
   localparam int RES_W = 10;
   localparam int TAD_PER_CONV = 11;
   localparam int RC_DIV = 16;
   localparam int ABORT_TADS = 2;
   localparam int RC_START_CYC = 4;
   localparam logic [3:0] LAST_TAD = 4'(TAD_PER_CONV - 1);
   localparam logic [3:0] RC_LAST = 4'(RC_DIV - 1);
   localparam logic [1:0] HOLD_LAST = 2'(ABORT_TADS - 1);
   localparam logic [4:0] TEMP_CHAN = 5'h0a;
   // Register offsets on the plain register port.
   localparam logic [2:0] OFS_CTL0 = 3'h0;
   localparam logic [2:0] OFS_CTL1 = 3'h1;
   localparam logic [2:0] OFS_RESH = 3'h2;
   localparam logic [2:0] OFS_RESL = 3'h3;
   localparam logic [2:0] OFS_ABEC = 3'h4;
   localparam logic [2:0] OFS_STAT = 3'h5;
   // Field positions.
   localparam int CTL0_ON = 0;
   localparam int CTL0_GO = 1;
   localparam int CTL0_CHS = 2;
   localparam int CTL1_CS = 4;
   localparam int CTL1_IE = 7;
   localparam int ABEC_TSEN = 0;
   localparam int STAT_FLAG = 0;
   localparam int STAT_BUSY = 1;
   // Reset values.
   localparam logic [4:0] CHS_RST = 5'h00;
   localparam logic [2:0] CS_RST = 3'h0;
   localparam logic [RES_W-1:0] RESULT_RST = 10'h000;
   // Conversion clock select codes and divider terminal counts.
   localparam logic [2:0] CS_DIV8 = 3'b001;
   localparam logic [2:0] CS_DIV16 = 3'b101;
   localparam logic [2:0] CS_DIV32 = 3'b010;
   localparam logic [2:0] CS_DIV64 = 3'b110;
   localparam logic [1:0] CS_RC = 2'b11;
   localparam logic [5:0] LIM_DIV8 = 6'h07;
   localparam logic [5:0] LIM_DIV16 = 6'h0f;
   localparam logic [5:0] LIM_DIV32 = 6'h1f;
   localparam logic [5:0] LIM_DIV64 = 6'h3f;
   // Channel map limits.
   localparam logic [4:0] CH_INT_LAST = 5'h0c;
   localparam logic [4:0] CH_PIN_FIRST = 5'h10;
   localparam logic [4:0] CH_PIN_LAST_S = 5'h15;
   localparam logic [4:0] CH_PIN_LAST_L = 5'h17;
   // Sequencer states.
   typedef enum logic [3:0] {
      SAC_IDLE = 4'b0001,
      SAC_WAIT = 4'b0010,
      SAC_CONV = 4'b0100,
      SAC_HOLD = 4'b1000
   } sac_state_t;
   // Controls toward the analog front end.
   typedef struct packed {
      logic [4:0] chan;
      logic connect;
      logic sample;
      logic [RES_W-1:0] trial;
      logic power;
      logic temp_en;
      logic ot_en;
   } sac_afe_t;
endpackage

/* File: verilog/sac_top.sv */
// Successive-approximation converter sequencer with its register port.
//
// What this block does
// RULE1: Convert the selected input into ten bits by successive approximation.
// RULE2: Store each result right-justified across the high and low result registers.
// RULE3: All inputs share one multiplexer into one sample-and-hold feeding the converter.
// RULE4: The five-bit channel_select field picks the channel on the sample-and-hold.
// RULE5: Nineteen channels on the small variant, twenty-one on the large one.
// RULE6: Channel ten carries the die-temperature circuit output.
// RULE7: temp_sense_enable alone enables temperature sensing and overtemperature shutdown.
// RULE8: Clock select 001,101,010,110 divide by 8,16,32,64; x11 picks RC clock.
// RULE9: The RC conversion clock is the internal oscillator divided by sixteen.
// RULE10: A full conversion takes exactly eleven bit periods.
// RULE11: Completion can raise an interrupt that wakes the device from Sleep.
// RULE12: Software waits a settling delay after changing channel before converting.
// RULE13: Divider clock sources follow system clock changes; the RC source does not.
// RULE14: Software picks a setting meeting the minimum bit period.
// RULE15: Software selects the RC clock only for conversions during Sleep.
// RULE16: The internal band gap is the only reference; no external selection.
// RULE17: Software makes a pin analog through its tri-state and select controls.
// RULE18: Setting go_done while enabled starts; go_done stays high while converting.
// RULE19: On completion clear go_done, set the done flag, load the result.
// RULE20: An early clear of go_done aborts and keeps the previous result.
`timescale 1ns/1ps
`default_nettype none
module sac_top #(
   parameter bit LARGE_VARIANT = 1'b0
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_b,
   // Register port.
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   // Analog front end.
   input wire logic cmp_in,
   input wire logic rc_osc,
   output sac_pkg::sac_afe_t afe,
   // System status.
   input wire logic sleep,
   output logic done_irq,
   output logic wake
);
   import sac_pkg::*;

   sac_state_t st_q;
   logic on_q, go_q, ie_q, tsen_q, flag_q, busy_q, sleep_off_q;
   logic [4:0] chs_q;
   logic [2:0] cs_q;
   logic [RES_W-1:0] result_q, sar_q, mask_q, decide;
   logic [3:0] tad_n_q, rc_cnt_q;
   logic [1:0] hold_n_q;
   logic [5:0] div_cnt_q;
   logic [2:0] wait_q;
   logic rc_s1_q, rc_s2_q, rc_s3_q, cmp_s1_q, cmp_s2_q;
   logic wr_ctl0, rc_mode, rc_rise, tad_tick, start, sw_abort, off_abort;
   logic abort, last;

   // Terminal count of the system clock divider for each select code.
   function automatic logic [5:0] div_lim(input logic [2:0] cs);
      case (cs)
         CS_DIV16: div_lim = LIM_DIV16;
         CS_DIV32: div_lim = LIM_DIV32;
         CS_DIV64: div_lim = LIM_DIV64;
         default: div_lim = LIM_DIV8;
      endcase
   endfunction

   // True for channel codes that exist on this variant.
   function automatic logic chan_ok(input logic [4:0] ch);
      logic [4:0] top;
      top = LARGE_VARIANT ? CH_PIN_LAST_L : CH_PIN_LAST_S;
      chan_ok = (ch <= CH_INT_LAST) || (ch >= CH_PIN_FIRST && ch <= top);
   endfunction

   // Both asynchronous inputs pass two flip-flops before use.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rc_s1_q <= 1'b0;
         rc_s2_q <= 1'b0;
         rc_s3_q <= 1'b0;
         cmp_s1_q <= 1'b0;
         cmp_s2_q <= 1'b0;
      end else begin
         rc_s1_q <= rc_osc;
         rc_s2_q <= rc_s1_q;
         rc_s3_q <= rc_s2_q;
         cmp_s1_q <= cmp_in;
         cmp_s2_q <= cmp_s1_q;
      end
   end

   // Decode of bus events and conversion conditions.
   assign wr_ctl0 = wr && (addr == OFS_CTL0);
   assign rc_mode = (cs_q[1:0] == CS_RC); // RULE8
   assign rc_rise = rc_s2_q && !rc_s3_q;
   assign tad_tick = rc_mode ? (rc_rise && rc_cnt_q == RC_LAST) // RULE9
      : (div_cnt_q == div_lim(cs_q)); // RULE8 RULE13
   // A start needs the converter already on before this write.
   assign start = wr_ctl0 && wdata[CTL0_GO] && wdata[CTL0_ON] && on_q
      && st_q == SAC_IDLE && !(sleep && !rc_mode); // RULE18
   assign sw_abort = wr_ctl0 && !wdata[CTL0_GO]
      && (st_q == SAC_CONV || st_q == SAC_WAIT); // RULE20
   assign off_abort = (st_q == SAC_CONV || st_q == SAC_WAIT)
      && (!on_q || (sleep && !rc_mode));
   assign abort = sw_abort || off_abort;
   assign last = st_q == SAC_CONV && tad_tick && tad_n_q == LAST_TAD;
   // Keep the trial bit when the held input is at or above the trial level.
   assign decide = cmp_s2_q ? (sar_q | mask_q) : sar_q; // RULE1

   // System clock divider; it simply counts clk, so clock changes carry over.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         div_cnt_q <= 6'h00;
      end else if (st_q == SAC_IDLE || st_q == SAC_WAIT || rc_mode) begin
         div_cnt_q <= 6'h00;
      end else if (tad_tick) begin
         div_cnt_q <= 6'h00; // RULE13
      end else begin
         div_cnt_q <= div_cnt_q + 6'h01;
      end
   end

   // The RC clock counts synchronised oscillator edges; it restarts while
   // idle or waiting so that the first bit period is a full one.
   always_ff @(posedge clk) begin
      if (!rst_b || st_q == SAC_IDLE || st_q == SAC_WAIT) begin
         rc_cnt_q <= 4'h0; // RULE10
      end else if (rc_rise) begin
         rc_cnt_q <= rc_cnt_q + 4'h1; // RULE9
      end
   end

   // Conversion sequencer: BIT_CONVERSION_PERIOD zero holds the sample, ten TADs decide bits.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st_q <= SAC_IDLE;
         tad_n_q <= 4'h0;
         hold_n_q <= 2'h0;
         wait_q <= 3'h0;
         sar_q <= RESULT_RST;
         mask_q <= RESULT_RST;
      end else begin
         case (st_q)
            SAC_IDLE: begin
               if (start) begin
                  // The RC source waits a little so the core can sleep first.
                  st_q <= rc_mode ? SAC_WAIT : SAC_CONV;
                  wait_q <= 3'h0;
                  tad_n_q <= 4'h0;
                  sar_q <= RESULT_RST;
                  mask_q <= {1'b1, {(RES_W-1){1'b0}}}; // RULE1
               end
            end
            SAC_WAIT: begin
               if (abort) begin
                  st_q <= SAC_IDLE;
               end else if (wait_q == 3'(RC_START_CYC - 1)) begin
                  st_q <= SAC_CONV;
               end else begin
                  wait_q <= wait_q + 3'h1;
               end
            end
            SAC_CONV: begin
               if (abort) begin
                  st_q <= SAC_HOLD; // RULE20
                  hold_n_q <= 2'h0;
               end else if (tad_tick) begin
                  tad_n_q <= tad_n_q + 4'h1; // RULE10
                  if (tad_n_q != 4'h0) begin
                     sar_q <= decide; // RULE1
                     mask_q <= mask_q >> 1;
                  end
                  if (last) begin
                     st_q <= SAC_IDLE; // RULE10
                  end
               end
            end
            SAC_HOLD: begin
               // Two TADs pass after an abort in conversion before a new start is taken.
               if (tad_tick) begin
                  hold_n_q <= hold_n_q + 2'h1;
                  if (hold_n_q == HOLD_LAST) begin
                     st_q <= SAC_IDLE;
                  end
               end
            end
            default: begin
               st_q <= SAC_IDLE;
            end
         endcase
      end
   end

   // Converter enable, channel and go_done, written through control_0.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         on_q <= 1'b0;
         chs_q <= CHS_RST;
         go_q <= 1'b0;
      end else begin
         if (wr_ctl0) begin
            on_q <= wdata[CTL0_ON];
            chs_q <= wdata[CTL0_CHS +: 5]; // RULE4
         end
         if (last) begin
            go_q <= 1'b0; // RULE19
         end else if (start) begin
            go_q <= 1'b1; // RULE18
         end else if (sw_abort || off_abort) begin
            go_q <= 1'b0; // RULE20
         end else if (wr_ctl0 && st_q == SAC_IDLE) begin
            go_q <= 1'b0;
         end
      end
   end

   // Clock select, interrupt enable and temperature enable.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cs_q <= CS_RST;
         ie_q <= 1'b0;
         tsen_q <= 1'b0;
      end else begin
         if (wr && addr == OFS_CTL1) begin
            cs_q <= wdata[CTL1_CS +: 3]; // RULE8
            ie_q <= wdata[CTL1_IE];
         end
         if (wr && addr == OFS_ABEC) begin
            tsen_q <= wdata[ABEC_TSEN]; // RULE7
         end
      end
   end

   // Result pair and done flag; a completion beats a clear in the same cycle.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         result_q <= RESULT_RST;
         flag_q <= 1'b0;
      end else begin
         if (last) begin
            result_q <= decide; // RULE19
         end
         if (last) begin
            flag_q <= 1'b1; // RULE19
         end else if (wr && addr == OFS_STAT && !wdata[STAT_FLAG]) begin
            flag_q <= 1'b0;
         end
      end
   end

   // A sleeping conversion with interrupts off powers the converter down.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sleep_off_q <= 1'b0;
      end else if (!sleep) begin
         sleep_off_q <= 1'b0;
      end else if (last && !ie_q) begin
         sleep_off_q <= 1'b1;
      end
   end

   // Front end drive: the mux selects, the single hold stage samples or holds.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         afe <= '0;
      end else begin
         afe.chan <= chs_q; // RULE3 RULE4
         // Unimplemented codes, and the cold temperature node, connect nothing.
         afe.connect <= on_q && chan_ok(chs_q) // RULE5
            && !(chs_q == TEMP_CHAN && !tsen_q); // RULE6
         afe.sample <= on_q && st_q != SAC_CONV; // RULE3
         // Trial code to the DAC; the band gap is the fixed reference.
         afe.trial <= (st_q == SAC_CONV) ? (sar_q | mask_q) : RESULT_RST; // RULE16
         afe.power <= on_q && !sleep_off_q && !(sleep && !rc_mode);
         afe.temp_en <= tsen_q; // RULE7
         afe.ot_en <= tsen_q; // RULE7
      end
   end

   // Interrupt and wake outputs follow the sticky done flag.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         done_irq <= 1'b0;
         wake <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         done_irq <= ie_q && flag_q; // RULE11
         wake <= ie_q && flag_q && sleep; // RULE11
         busy_q <= st_q != SAC_IDLE;
      end
   end

   // Read data stand for exactly the cycle after the read strobe.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rdata <= 8'h00;
      end else if (rd) begin
         case (addr)
            OFS_CTL0: rdata <= {1'b0, chs_q, go_q, on_q};
            OFS_CTL1: rdata <= {ie_q, cs_q, 4'h0};
            OFS_RESH: rdata <= {6'h00, result_q[9:8]}; // RULE2
            OFS_RESL: rdata <= result_q[7:0]; // RULE2
            OFS_ABEC: rdata <= {7'h00, tsen_q};
            OFS_STAT: rdata <= {6'h00, busy_q, flag_q};
            default: rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

   // Helper counters that only the checks below read.
   logic [3:0] chk_ticks_q;
   logic [4:0] chk_rc_q;
   always_ff @(posedge clk) begin
      if (!rst_b || start) begin
         chk_ticks_q <= 4'h0;
      end else if (st_q == SAC_CONV && tad_tick) begin
         chk_ticks_q <= chk_ticks_q + 4'h1;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_b || st_q == SAC_IDLE || st_q == SAC_WAIT
         || (rc_mode && tad_tick)) begin
         chk_rc_q <= 5'h00;
      end else if (rc_rise) begin
         chk_rc_q <= chk_rc_q + 5'h01;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   // Seven quiet cycles between ticks of the divide-by-8 clock.
   sequence s_quiet7;
      !tad_tick [*7];
   endsequence
   // Completion shows as cleared go_done beside a set flag.
   sequence s_done_seen;
      ##1 (!go_q && flag_q && st_q == SAC_IDLE);
   endsequence

   AST_GO_HOLDS: assert property (st_q == SAC_CONV |-> go_q) // RULE18
      else $error("go_done low during a conversion");
   AST_DONE_SEEN: assert property (last |-> s_done_seen) // RULE19
      else $error("completion did not clear go_done and set the flag");
   AST_ABORT_KEEPS: assert property (
      (st_q == SAC_CONV && abort) |=> $stable(result_q) [*3]) // RULE20
      else $error("abort disturbed the result pair");
   AST_ELEVEN_TAD: assert property (last |-> chk_ticks_q == 4'ha) // RULE10
      else $error("conversion did not take eleven bit periods");
   AST_DIV8: assert property ((st_q == SAC_CONV && tad_tick
      && cs_q == CS_DIV8 && tad_n_q < 4'h9 && !wr) |=> s_quiet7) // RULE8
      else $error("divide-by-8 bit period wrong");
   AST_RC_DIV16: assert property (
      (rc_mode && tad_tick) |-> chk_rc_q == 5'h0f) // RULE9
      else $error("RC bit period is not sixteen oscillator edges");
   AST_TEMP_EN: assert property (
      ##1 (afe.temp_en == $past(tsen_q) && afe.ot_en == afe.temp_en)) // RULE7
      else $error("temperature enables do not follow temp_sense_enable");
   AST_RESULT_RJ: assert property ((rd && addr == OFS_RESH)
      |=> rdata == {6'h00, result_q[9:8]}) // RULE2
      else $error("high result byte is not right-justified");
   AST_HOLD_CONV: assert property (
      (st_q == SAC_CONV && tad_n_q != 4'h0) |=> !afe.sample) // RULE3
      else $error("sample-and-hold tracking during conversion");
   AST_WAKE: assert property ((last && ie_q && sleep) |-> ##2 wake) // RULE11
      else $error("completion did not wake the sleeping device");

endmodule // sac_top
`default_nettype wire

/* File: verification/sac_afe_model.sv */
// Behavioural analog front end: sources, sample-and-hold, comparator.
`timescale 1ns/1ps
`default_nettype none
module sac_afe_model #(
   parameter logic [9:0] TEMP_CODE = 10'h1c3,
   parameter int RC_HALF_NS = 85
) (
   // Clock.
   input wire logic clk,
   // Controls from the converter.
   input wire sac_pkg::sac_afe_t afe,
   // Comparator decision and free-running oscillator.
   output logic cmp_in,
   output logic rc_osc
);
   import sac_pkg::*;
   logic [9:0] held_q;
   logic [9:0] src;
   // Every channel has its own level; channel ten is the die sensor.
   always_comb begin
      if (afe.chan == TEMP_CHAN) begin
         src = TEMP_CODE;
      end else begin
         src = {afe.chan, 5'h0b} ^ 10'h2d6;
      end
   end
   // One shared hold stage tracks while sampling and freezes otherwise.
   always @(posedge clk) begin
      if (afe.sample) begin
         held_q <= src;
      end
   end
   // An unconnected input floats, so the decision then toggles.
   initial cmp_in = 1'b0;
   always @(posedge clk) begin
      if (afe.connect) begin
         cmp_in <= (held_q >= afe.trial);
      end else begin
         cmp_in <= ~cmp_in;
      end
   end
   // The oscillator runs free with no phase tie to the system clock.
   initial begin
      rc_osc = 1'b0;
      forever #(RC_HALF_NS) rc_osc = ~rc_osc;
   end
endmodule // sac_afe_model
`default_nettype wire

/* File: verification/tb_sac_top.sv */
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
`default_nettype none
module tb_sac_top;
   import sac_pkg::*;
   localparam int HALF_RC = 85;
   localparam logic [9:0] TCODE = 10'h1c3;
   logic clk, rst_b, wr, rd, cmp_in, rc_osc, sleep, done_irq, wake;
   logic [2:0] addr;
   logic [7:0] wdata, rdata;
   sac_afe_t afe;
   int miscompares = 0;
   int total_checks = 0;
   int cyc = 0;
   int n, t0;
   logic [9:0] e;
   logic [4:0] channel_select [4] = '{5'h01, 5'h05, 5'h10, 5'h15};
   logic [2:0] css [4] = '{CS_DIV8, CS_DIV16, CS_DIV32, CS_DIV64};
   int dvs [4] = '{8, 16, 32, 64};
   logic [4:0] nch [4] = '{5'h0a, 5'h0d, 5'h16, 5'h15};
   logic [7:0] ncon [4] = '{8'h00, 8'h00, 8'h00, 8'h01};

   sac_top sac_top_inst (.clk(clk), .rst_b(rst_b), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .cmp_in(cmp_in),
      .rc_osc(rc_osc), .afe(afe), .sleep(sleep), .done_irq(done_irq),
      .wake(wake));
   sac_afe_model #(.TEMP_CODE(TCODE), .RC_HALF_NS(HALF_RC))
      sac_afe_model_inst (.clk(clk), .afe(afe), .cmp_in(cmp_in),
      .rc_osc(rc_osc));

   // System clock and a free cycle count.
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;

   // Level that the model presents on a non-temperature channel.
   function automatic logic [9:0] exp_code(input logic [4:0] ch);
      return {ch, 5'h0b} ^ 10'h2d6;
   endfunction

   // Verdict and end of run.
   task automatic close_out();
      if (miscompares == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Byte comparison.
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Cycle count comparison against a window.
   task automatic chk_rng(input int got, input int lo, input int hi);
      total_checks++;
      if (got < lo || got > hi) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, lo);
      end
   endtask

   // One-cycle register write.
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // One-cycle register read; data stand in the following cycle.
   task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask

   task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd_reg(a, d);
      chk8(d, exp);
   endtask

   // Configure, switch on, settle on the channel, then start.
   task automatic start_conv(input logic [4:0] ch, input logic [7:0] c1);
      wr_reg(OFS_CTL1, c1);
      wr_reg(OFS_STAT, 8'h00);
      wr_reg(OFS_CTL0, {1'b0, ch, 2'b01});
      repeat (20) @(posedge clk);
      wr_reg(OFS_CTL0, {1'b0, ch, 2'b11});
      t0 = cyc;
   endtask

   // Poll the start bit until it falls, under a bound.
   task automatic wait_done(output int cnt);
      logic [7:0] d;
      d = 8'h02;
      for (int i = 0; i < 2000 && d[CTL0_GO] !== 1'b0; i++) begin
         rd_reg(OFS_CTL0, d);
      end
      if (d[CTL0_GO] !== 1'b0) begin
         miscompares++;
         close_out();
      end
      cnt = cyc - t0;
   endtask

   initial begin
      rst_b = 1'b0;
      addr = 3'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      sleep = 1'b0;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      rd_chk(OFS_CTL0, 8'h00);
      rd_chk(OFS_RESH, 8'h00);
      rd_chk(OFS_STAT, 8'h00);
      wr_reg(3'h7, 8'hff);
      rd_chk(3'h6, 8'h00);
      rd_chk(3'h7, 8'h00);
      // Switching on and starting in one write must not start.
      wr_reg(OFS_CTL0, 8'h03);
      rd_chk(OFS_CTL0, 8'h01);
      // Each divider setting, timed and converted on a different channel.
      for (int k = 0; k < 4; k++) begin
         start_conv(channel_select[k], {1'b0, css[k], 4'h0});
         wait_done(n);
         chk_rng(n, 11 * dvs[k], 11 * dvs[k] + 8);
         e = exp_code(channel_select[k]);
         rd_chk(OFS_RESH, {6'h00, e[9:8]});
         rd_chk(OFS_RESL, e[7:0]);
         rd_chk(OFS_STAT, 8'h01);
         chk8({3'h0, afe.chan}, {3'h0, channel_select[k]});
      end
      wr_reg(OFS_RESL, 8'hff);
      rd_chk(OFS_RESL, e[7:0]);
      // Unimplemented or disabled channels stay disconnected; the implemented channel 5'h15 connects.
      for (int k = 0; k < 4; k++) begin
         wr_reg(OFS_CTL0, {1'b0, nch[k], 2'b01});
         repeat (2) @(negedge clk);
         chk8({7'h00, afe.connect}, ncon[k]);
      end
      chk8({6'h00, afe.temp_en, afe.ot_en}, 8'h00);
      wr_reg(OFS_ABEC, 8'h01);
      repeat (2) @(negedge clk);
      chk8({6'h00, afe.temp_en, afe.ot_en}, 8'h03);
      start_conv(TEMP_CHAN, {1'b0, CS_DIV16, 4'h0});
      wait_done(n);
      chk8({7'h00, afe.connect}, 8'h01);
      rd_chk(OFS_RESH, {6'h00, TCODE[9:8]});
      rd_chk(OFS_RESL, TCODE[7:0]);
      // Abort in mid-conversion keeps the earlier result.
      start_conv(5'h03, {1'b0, CS_DIV64, 4'h0});
      repeat (100) @(posedge clk);
      wr_reg(OFS_CTL0, 8'h0d);
      repeat (200) @(posedge clk);
      rd_chk(OFS_STAT, 8'h00);
      rd_chk(OFS_RESH, {6'h00, TCODE[9:8]});
      rd_chk(OFS_RESL, TCODE[7:0]);
      // RC clock conversions in Sleep wake the device.
      for (int k = 0; k < 2; k++) begin
         start_conv(5'h12, {1'b1, k[0], CS_RC, 4'h0});
         sleep <= 1'b1;
         for (int i = 0; i < 1000 && wake !== 1'b1; i++) begin
            @(negedge clk);
         end
         n = cyc - t0;
         chk8({6'h00, wake, done_irq}, 8'h03);
         if (wake !== 1'b1) begin
            close_out();
         end
         chk_rng(n, 11 * 16 * 2 * HALF_RC / 40, 11 * 16 * 2 * HALF_RC / 40 + 20);
         @(posedge clk);
         sleep <= 1'b0;
         e = exp_code(5'h12);
         rd_chk(OFS_RESL, e[7:0]);
         wr_reg(OFS_STAT, 8'h00);
         repeat (2) @(negedge clk);
         chk8({6'h00, wake, done_irq}, 8'h00);
      end
      close_out();
   end
endmodule // tb_sac_top
`default_nettype wire
